// *** hdl/pcrh_map.vh ***
`ifndef PCRH_MAP_VH
`define PCRH_MAP_VH
// Identifier word fields
`define PCRH_PNU_MSB 10
`define PCRH_RSV_BIT 11
`define PCRH_ID_LSB 12
`define PCRH_ID_MSB 15
// Index word fields
`define PCRH_SUB_LSB 8
`define PCRH_SUB_MSB 15
`define PCRH_PAGE_LSB 0
`define PCRH_PAGE_MSB 7
`define PCRH_PAGE_BIT 7
`define PCRH_PAGE_OFS 16'd2000
`define PCRH_PNU_MIN 16'd1
`define PCRH_PNU_MAX 16'd61999
// Request IDs
`define PCRH_RQ_NONE 4'h0
`define PCRH_RQ_READ 4'h1
`define PCRH_RQ_WR_W 4'h2
`define PCRH_RQ_WR_D 4'h3
`define PCRH_RQ_DESC 4'h4
`define PCRH_RQ_FRD 4'h6
`define PCRH_RQ_FWR_W 4'h7
`define PCRH_RQ_FWR_D 4'h8
`define PCRH_RQ_FCNT 4'h9
`define PCRH_RQ_FSV_D 4'hb
`define PCRH_RQ_FSV_W 4'hc
`define PCRH_RQ_SV_D 4'hd
`define PCRH_RQ_SV_W 4'he
// Response IDs
`define PCRH_RS_NONE 4'h0
`define PCRH_RS_W 4'h1
`define PCRH_RS_D 4'h2
`define PCRH_RS_DESC 4'h3
`define PCRH_RS_FW 4'h4
`define PCRH_RS_FD 4'h5
`define PCRH_RS_FCNT 4'h6
`define PCRH_RS_ERR 4'h7
`define PCRH_RS_NOAUTH 4'h8
// Fault numbers
`define PCRH_F_NOPAR 16'h0000
`define PCRH_F_RO 16'h0001
`define PCRH_F_MINMAX 16'h0002
`define PCRH_F_SUB 16'h0003
`define PCRH_F_NOFLD 16'h0004
`define PCRH_F_TYPE 16'h0005
`define PCRH_F_RSTONLY 16'h0006
`define PCRH_F_DESCRO 16'h0007
`define PCRH_F_NOMST 16'h000b
`define PCRH_F_KEY 16'h000c
`define PCRH_F_STATE 16'h0011
`define PCRH_F_DEACT 16'h0065
`define PCRH_F_WIDTH 16'h0066
`define PCRH_F_VALUE 16'h0068
`define PCRH_F_UNSUP 16'h006a
`define PCRH_F_LIMMIN 16'h00c8
`define PCRH_F_LIMMAX 16'h00c9
`define PCRH_F_ACCESS 16'h00cc
// Store status codes returned by parameter back end
`define PCRH_ST_OK 4'h0
`define PCRH_ST_RO 4'h1
`define PCRH_ST_MINMAX 4'h2
`define PCRH_ST_RSTONLY 4'h3
`define PCRH_ST_KEY 4'h4
`define PCRH_ST_STATE 4'h5
`define PCRH_ST_DEACT 4'h6
`define PCRH_ST_VALUE 4'h7
`define PCRH_ST_LIMMIN 4'h8
`define PCRH_ST_LIMMAX 4'h9
`define PCRH_ST_ACCESS 4'ha
`define PCRH_ST_WIDTH 4'hb
`define PCRH_TRUE 1'b1
`define PCRH_FALSE 1'b0
`endif

// *** hdl/pcrh_resp_reg.v ***
// =====================================
// Response word holding register
// =====================================
module pcrh_resp_reg #(
   parameter WIDTH = 16,
   parameter WORDS = 4
) (
   input wire clk_sys_in,                 // System clock
   input wire rstn_in,                    // Async reset, low
   input wire wr_en_in,                   // Load all words
   input wire [WIDTH*WORDS-1:0] wr_data_in, // Packed words
   output reg [WIDTH*WORDS-1:0] rd_data_out // Registered words
);
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_data_out <= {WIDTH*WORDS{1'b0}};
      end else if (wr_en_in) begin
         rd_data_out <= wr_data_in;
      end
   end
endmodule

// *** hdl/pcrh_top.v ***
// Behaviour
// - Channel is four words: identifier, index, value high, value low.
// - Identifier word is always handled as sixteen bits.
// - Bits 0..10 carry parameter number low part; range 1..61999.
// - Numbers of 2000 and up get an offset chosen by index word.
// - Reserved bit 11 is always sent as zero.
// - Bits 12..15 carry request ID in, response ID out.
// - Read value answers 1 for word, 2 for double word.
// - Word change answers 1, double-word change answers 2.
// - Descriptive element request answers 3, element chosen by index.
// - Field read answers 4/5 by width; field changes answer 4 or 5.
// - Field element count request answers 6 with the count.
// - Save requests also store to EEPROM; answers 5, 4, 2, 1.
// - Unexecutable request answers 7 with fault in low value word.
// - Change without master control or change permission answers 8.
// - Faults 0 no parameter, 1 read-only, 2 min/max, 3 subindex.
// - Fault 4 field request on non-field, 5 word/dword mismatch.
// - Fault 6 reset-only setting, 7 descriptive element unchangeable.
// - Fault 11 change without master control, 12 keyword missing.
// - Fault 17 request incompatible with operating state.
// - Fault 101 parameter deactivated, 102 channel too small.
// - Fault 104 value not permitted, 106 unsupported request.
// - Faults 200/201 tightened limits, 204 insufficient access.
// - Word values in fourth word, third zero; dwords use third high.
// - Cyclic: subindex in index bits 8..15, page in bits 0..7.
// - Page bit set adds 2000 to the parameter number.
`include "pcrh_map.vh"
module pcrh_top #(
   parameter W = 16
) (
   input wire clk_sys_in,          // System clock
   input wire rstn_in,             // Async reset, low
   input wire tlg_valid_in,        // New telegram received, pulse
   input wire [W-1:0] rq_ident_in, // Request identifier word
   input wire [W-1:0] rq_index_in, // Request index word
   input wire [W-1:0] rq_high_in,  // Request value high word
   input wire [W-1:0] rq_low_in,   // Request value low word
   input wire acyclic_in,          // Page offset from upper index bits
   input wire master_ctl_in,       // Master control mode active
   input wire change_perm_in,      // Permission to change parameters
   output reg par_req_out,         // Parameter lookup strobe
   output reg [W-1:0] par_num_out, // Full parameter number
   output reg [7:0] par_sub_out,   // Subindex / element select
   input wire par_exists_in,       // Parameter exists
   input wire par_dword_in,        // Parameter is double word
   input wire par_field_in,        // Parameter is a field
   input wire [W-1:0] par_count_in, // Field element count
   input wire [W-1:0] par_rd_high_in, // Read value high
   input wire [W-1:0] par_rd_low_in,  // Read value low
   input wire [W-1:0] par_desc_in,    // Descriptive element
   input wire par_ack_in,          // Lookup answer valid
   output reg par_wr_out,          // Write strobe
   output reg par_save_out,        // Also store to EEPROM
   output reg [W-1:0] par_wr_high_out, // Write value high
   output reg [W-1:0] par_wr_low_out,  // Write value low
   input wire [3:0] par_wr_status_in,  // Write status code
   output wire [W-1:0] rs_ident_out, // Response identifier word
   output wire [W-1:0] rs_index_out, // Response index word
   output wire [W-1:0] rs_high_out,  // Response value high word
   output wire [W-1:0] rs_low_out,   // Response value low word
   output reg busy_out             // Request in progress
);
   // ==========================================
   // States
   // ==========================================
   localparam S_IDLE = 2'd0;
   localparam S_LOOK = 2'd1;
   localparam S_WRITE = 2'd2;
   localparam S_DONE = 2'd3;

   reg [1:0] state;
   reg [3:0] last_id;
   reg [3:0] cur_id;
   reg [W-1:0] cur_index;
   reg [W-1:0] cur_high;
   reg [W-1:0] cur_low;
   reg [10:0] cur_pnu;
   reg [3:0] rs_id;
   reg [W-1:0] rs_high;
   reg [W-1:0] rs_low;
   reg rs_load;
   wire [4*W-1:0] rs_packed;

   // ==========================================
   // Request field decode
   // ==========================================
   wire [3:0] in_id = rq_ident_in[`PCRH_ID_MSB:`PCRH_ID_LSB];
   // Acyclic swaps page and subindex bytes
   wire [7:0] page_byte = acyclic_in ?
      rq_index_in[`PCRH_SUB_MSB:`PCRH_SUB_LSB] :
      rq_index_in[`PCRH_PAGE_MSB:`PCRH_PAGE_LSB];
   wire [7:0] sub_byte = acyclic_in ?
      rq_index_in[`PCRH_PAGE_MSB:`PCRH_PAGE_LSB] :
      rq_index_in[`PCRH_SUB_MSB:`PCRH_SUB_LSB];
   wire page_set = page_byte[`PCRH_PAGE_BIT];
   wire [W-1:0] base_pnu = {5'h00, rq_ident_in[`PCRH_PNU_MSB:0]};
   wire [W-1:0] full_pnu = page_set ? base_pnu + `PCRH_PAGE_OFS :
      base_pnu;
   // Number zero refused before any lookup
   wire pnu_ok = (full_pnu >= `PCRH_PNU_MIN) &&
      (full_pnu <= `PCRH_PNU_MAX);

   // Request classes
   wire is_field = (cur_id == `PCRH_RQ_FRD) || (cur_id == `PCRH_RQ_FWR_W) ||
      (cur_id == `PCRH_RQ_FWR_D) || (cur_id == `PCRH_RQ_FSV_D) ||
      (cur_id == `PCRH_RQ_FSV_W);
   wire is_wr_w = (cur_id == `PCRH_RQ_WR_W) || (cur_id == `PCRH_RQ_SV_W) ||
      (cur_id == `PCRH_RQ_FWR_W) || (cur_id == `PCRH_RQ_FSV_W);
   wire is_wr_d = (cur_id == `PCRH_RQ_WR_D) || (cur_id == `PCRH_RQ_SV_D) ||
      (cur_id == `PCRH_RQ_FWR_D) || (cur_id == `PCRH_RQ_FSV_D);
   wire is_save = (cur_id == `PCRH_RQ_FSV_D) || (cur_id == `PCRH_RQ_FSV_W) ||
      (cur_id == `PCRH_RQ_SV_D) || (cur_id == `PCRH_RQ_SV_W);
   wire is_write = is_wr_w || is_wr_d;
   wire is_read = (cur_id == `PCRH_RQ_READ) || (cur_id == `PCRH_RQ_DESC) ||
      (cur_id == `PCRH_RQ_FRD) || (cur_id == `PCRH_RQ_FCNT);
   wire supported = is_read || is_write;
   wire cur_sub_nz = (par_sub_out != 8'h00);

   // ==========================================
   // Write status to fault number
   // ==========================================
   reg [W-1:0] st_fault;
   always @* begin
      case (par_wr_status_in)
         `PCRH_ST_RO: st_fault = `PCRH_F_RO;
         `PCRH_ST_MINMAX: st_fault = `PCRH_F_MINMAX;
         `PCRH_ST_RSTONLY: st_fault = `PCRH_F_RSTONLY;
         `PCRH_ST_KEY: st_fault = `PCRH_F_KEY;
         `PCRH_ST_STATE: st_fault = `PCRH_F_STATE;
         `PCRH_ST_DEACT: st_fault = `PCRH_F_DEACT;
         `PCRH_ST_WIDTH: st_fault = `PCRH_F_WIDTH;
         `PCRH_ST_VALUE: st_fault = `PCRH_F_VALUE;
         `PCRH_ST_LIMMIN: st_fault = `PCRH_F_LIMMIN;
         `PCRH_ST_LIMMAX: st_fault = `PCRH_F_LIMMAX;
         `PCRH_ST_ACCESS: st_fault = `PCRH_F_ACCESS;
         // Unknown store status reported as bad value
         default: st_fault = `PCRH_F_VALUE;
      endcase
   end

   // ==========================================
   // Sequencer
   // ==========================================
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= S_IDLE;
         last_id <= `PCRH_RQ_NONE;
         cur_id <= `PCRH_RQ_NONE;
         cur_index <= {W{1'b0}};
         cur_high <= {W{1'b0}};
         cur_low <= {W{1'b0}};
         cur_pnu <= 11'h000;
         par_req_out <= `PCRH_FALSE;
         par_num_out <= {W{1'b0}};
         par_sub_out <= 8'h00;
         par_wr_out <= `PCRH_FALSE;
         par_save_out <= `PCRH_FALSE;
         par_wr_high_out <= {W{1'b0}};
         par_wr_low_out <= {W{1'b0}};
         rs_id <= `PCRH_RS_NONE;
         rs_high <= {W{1'b0}};
         rs_low <= {W{1'b0}};
         rs_load <= `PCRH_FALSE;
         busy_out <= `PCRH_FALSE;
      end else begin
         par_req_out <= `PCRH_FALSE;
         par_wr_out <= `PCRH_FALSE;
         rs_load <= `PCRH_FALSE;
         case (state)
            S_IDLE: begin
               // Repeated request ID keeps last response
               if (tlg_valid_in && (in_id != last_id)) begin
                  last_id <= in_id;
                  cur_id <= in_id;
                  cur_index <= rq_index_in;
                  cur_high <= rq_high_in;
                  cur_low <= rq_low_in;
                  cur_pnu <= rq_ident_in[`PCRH_PNU_MSB:0];
                  par_num_out <= full_pnu;
                  par_sub_out <= sub_byte;
                  busy_out <= `PCRH_TRUE;
                  // Empty request answers at once, no lookup
                  if (in_id == `PCRH_RQ_NONE) begin
                     rs_id <= `PCRH_RS_NONE;
                     rs_high <= {W{1'b0}};
                     rs_low <= {W{1'b0}};
                     state <= S_DONE;
                  end else if (!pnu_ok) begin
                     rs_id <= `PCRH_RS_ERR;
                     rs_high <= {W{1'b0}};
                     rs_low <= `PCRH_F_NOPAR;
                     state <= S_DONE;
                  end else begin
                     par_req_out <= `PCRH_TRUE;
                     state <= S_LOOK;
                  end
               end
            end
            S_LOOK: begin
               if (par_ack_in) begin
                  state <= S_DONE;
                  rs_high <= {W{1'b0}};
                  rs_id <= `PCRH_RS_ERR;
                  // Checks in priority order; first failing one answers
                  if (!supported) begin
                     rs_low <= `PCRH_F_UNSUP;
                     rs_id <= `PCRH_RS_ERR;
                  end else if (!par_exists_in) begin
                     rs_low <= `PCRH_F_NOPAR;
                  end else if (is_write && (!master_ctl_in ||
                        !change_perm_in)) begin
                     rs_id <= `PCRH_RS_NOAUTH;
                     rs_low <= master_ctl_in ? `PCRH_F_ACCESS :
                        `PCRH_F_NOMST;
                  end else if (is_field && !par_field_in && cur_sub_nz) begin
                     rs_low <= `PCRH_F_NOFLD;
                  end else if (is_field && par_field_in &&
                        (par_sub_out >= par_count_in[7:0])) begin
                     rs_low <= `PCRH_F_SUB;
                  end else if ((is_wr_w && par_dword_in) ||
                        (is_wr_d && !par_dword_in)) begin
                     rs_low <= `PCRH_F_TYPE;
                  end else if (is_write) begin
                     par_wr_out <= `PCRH_TRUE;
                     par_save_out <= is_save;
                     par_wr_high_out <= is_wr_d ? cur_high :
                        {W{1'b0}};
                     par_wr_low_out <= cur_low;
                     state <= S_WRITE;
                  end else if (cur_id == `PCRH_RQ_DESC) begin
                     rs_id <= `PCRH_RS_DESC;
                     rs_low <= par_desc_in;
                  end else if (cur_id == `PCRH_RQ_FCNT) begin
                     rs_id <= `PCRH_RS_FCNT;
                     rs_low <= par_count_in;
                  end else begin
                     if (cur_id == `PCRH_RQ_FRD) begin
                        rs_id <= par_dword_in ? `PCRH_RS_FD :
                           `PCRH_RS_FW;
                     end else begin
                        rs_id <= par_dword_in ? `PCRH_RS_D :
                           `PCRH_RS_W;
                     end
                     rs_high <= par_dword_in ? par_rd_high_in :
                        {W{1'b0}};
                     rs_low <= par_rd_low_in;
                  end
               end
            end
            S_WRITE: begin
               if (par_ack_in) begin
                  state <= S_DONE;
                  // Positive answer echoes the stored value
                  if (par_wr_status_in == `PCRH_ST_OK) begin
                     if (is_field) begin
                        rs_id <= is_wr_d ? `PCRH_RS_FD :
                           `PCRH_RS_FW;
                     end else begin
                        rs_id <= is_wr_d ? `PCRH_RS_D :
                           `PCRH_RS_W;
                     end
                     rs_high <= is_wr_d ? cur_high : {W{1'b0}};
                     rs_low <= cur_low;
                  end else begin
                     rs_id <= `PCRH_RS_ERR;
                     rs_high <= {W{1'b0}};
                     rs_low <= st_fault;
                  end
               end
            end
            default: begin
               // Busy falls one cycle before the response loads
               rs_load <= `PCRH_TRUE;
               busy_out <= `PCRH_FALSE;
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // Response words
   // ==========================================
   // Reserved bit forced zero; index echoed
   wire [W-1:0] rs_ident = {rs_id, 1'b0, cur_pnu};
   pcrh_resp_reg #(
      .WIDTH(W),
      .WORDS(4)
   ) u_resp (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .wr_en_in(rs_load),
      .wr_data_in({rs_ident, cur_index, rs_high, rs_low}),
      .rd_data_out(rs_packed)
   );
   assign rs_ident_out = rs_packed[4*W-1:3*W];
   assign rs_index_out = rs_packed[3*W-1:2*W];
   assign rs_high_out = rs_packed[2*W-1:W];
   assign rs_low_out = rs_packed[W-1:0];
endmodule

// *** bench/pcrh_monitor.sv ***
module pcrh_monitor #(
   parameter W = 16
) (
   input wire logic clk_sys_in, // Clock
   input wire logic rstn_in, // Reset, low
   input wire logic tlg_valid_in, // Telegram
   input wire logic [W-1:0] rq_ident_in, // Ident
   input wire logic [W-1:0] rq_index_in, // Index
   input wire logic acyclic_in, // Page mode
   input wire logic par_req_out, // Lookup
   input wire logic [W-1:0] par_num_out, // Number
   input wire logic [7:0] par_sub_out, // Subindex
   input wire logic par_ack_in, // Answer
   input wire logic par_wr_out, // Write
   input wire logic [W-1:0] rs_ident_out, // Ident
   input wire logic [W-1:0] rs_high_out, // High
   input wire logic [W-1:0] rs_low_out, // Low
   input wire logic busy_out // Busy
);
   timeunit 1ns;
   timeprecision 1ns;
   wire pg = acyclic_in ? rq_index_in[15] : rq_index_in[7];
   wire [W-1:0] num = {5'h00, rq_ident_in[10:0]} + (pg ? 16'h07d0 : 16'h0000);
   wire [7:0] sub = acyclic_in ? rq_index_in[7:0] : rq_index_in[15:8];
   wire [3:0] rid = rs_ident_out[15:12];
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (!rstn_in);
   // ====================
   // Assertions
   chk_resv_zero:
      assert property (rs_ident_out[11] == 1'b0)
      else $error("reserved ident bit set");
   chk_resp_range:
      assert property (rid <= 4'h8)
      else $error("response id out of range");
   chk_num_page:
      assert property (par_req_out |-> par_num_out == $past(num))
      else $error("parameter number offset wrong");
   chk_sub_pick:
      assert property (par_req_out |-> par_sub_out == $past(sub))
      else $error("subindex byte wrong");
   chk_word_high:
      assert property ((rid == 4'h1 || rid == 4'h4) |-> rs_high_out == 16'h0000)
      else $error("word response high not zero");
   chk_resp_stand:
      assert property (($changed(rs_ident_out) || $changed(rs_low_out)) |->
         $past(busy_out, 2))
      else $error("response changed without request");
   chk_wr_ack:
      assert property (par_wr_out |-> $past(par_ack_in))
      else $error("write without lookup answer");
   chk_wr_once:
      assert property (par_wr_out |=> !par_wr_out)
      else $error("write strobe too long");
   chk_busy_ignore:
      assert property (tlg_valid_in && busy_out |=> !par_req_out)
      else $error("telegram taken while busy");
   chk_busy_end:
      assert property ($rose(busy_out) |-> ##[1:40] !busy_out)
      else $error("request never finished");
   cover property (par_wr_out);
   cover property (rid == 4'h8);
   cover property (tlg_valid_in && busy_out);
endmodule
bind pcrh_top pcrh_monitor #(.W(W)) u_mon (
   .clk_sys_in, .rstn_in, .tlg_valid_in, .rq_ident_in, .rq_index_in,
   .acyclic_in, .par_req_out, .par_num_out, .par_sub_out, .par_ack_in,
   .par_wr_out, .rs_ident_out, .rs_high_out, .rs_low_out, .busy_out
);

// *** bench/pcrh_param_model.sv ***
module pcrh_param_model (
   input wire logic clk_sys_in, // Clock
   input wire logic rstn_in, // Reset, low
   input wire logic req_in, // Lookup strobe
   input wire logic wr_in, // Write strobe
   input wire logic [15:0] num_in, // Number
   input wire logic [7:0] sub_in, // Subindex
   input wire logic [3:0] lat_in, // Answer delay
   input wire logic [3:0] st_in, // Write result
   output logic ack_out, // Answer valid
   output logic exists_out, // Known
   output logic dword_out, // Double word
   output logic field_out, // Field
   output logic [15:0] count_out, // Elements
   output logic [15:0] high_out, // Value high
   output logic [15:0] low_out, // Value low
   output logic [15:0] desc_out, // Description
   output logic [3:0] status_out // Write status
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pend;
   logic [3:0] cnt;
   logic ex, dw, fl;
   logic [15:0] hi, lo, ds;
   // ====================
   // Answer timing
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pend <= 1'b0;
         cnt <= 4'h0;
      end else if (req_in || wr_in) begin
         pend <= 1'b1;
         cnt <= lat_in;
      end else if (pend && cnt == 4'h0) begin
         pend <= 1'b0;
      end else if (pend) begin
         cnt <= cnt - 4'h1;
      end
   end
   // ====================
   // Contents, inverted outside the answer
   always_comb begin
      ack_out = pend && cnt == 4'h0;
      dw = num_in == 16'h07d5;
      fl = num_in == 16'h001e;
      ex = dw || fl || num_in == 16'h0005;
      hi = dw ? 16'h1234 : 16'h0000;
      lo = num_in ^ 16'h5a5a;
      ds = 16'h00d0 | {8'h00, sub_in};
      exists_out = ack_out ? ex : !ex;
      dword_out = ack_out ? dw : !dw;
      field_out = ack_out ? fl : !fl;
      count_out = ack_out ? 16'h0004 : 16'hfffb;
      high_out = ack_out ? hi : ~hi;
      low_out = ack_out ? lo : ~lo;
      desc_out = ack_out ? ds : ~ds;
      status_out = ack_out ? st_in : ~st_in;
   end
endmodule

// *** bench/pcrh_top_tb_top.sv ***
module pcrh_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [10:0] P5 = 11'h005;
   localparam logic [10:0] P30 = 11'h01e;
   localparam logic [15:0] Z = 16'h0000;
   logic clk_sys_in = 1'b0;
   logic rstn_in = 1'b0;
   logic tlg_valid_in = 1'b0;
   logic acyclic_in = 1'b0;
   logic master_ctl_in = 1'b1;
   logic change_perm_in = 1'b1;
   logic [15:0] rq_ident_in = 16'h0000;
   logic [15:0] rq_index_in = 16'h0000;
   logic [15:0] rq_high_in = 16'h0000; // Word values
   logic [15:0] rq_low_in = 16'h0042;
   logic [3:0] lat = 4'h0;
   logic [3:0] st = 4'h0;
   logic sv_exp = 1'b0;
   logic [15:0] flt [1:11];
   wire par_req_out, par_wr_out, par_save_out, busy_out, par_ack_in;
   wire par_exists_in, par_dword_in, par_field_in;
   wire [7:0] par_sub_out;
   wire [3:0] par_wr_status_in;
   wire [15:0] par_num_out, par_wr_high_out, par_wr_low_out, par_count_in;
   wire [15:0] par_rd_high_in, par_rd_low_in, par_desc_in;
   wire [15:0] rs_ident_out, rs_index_out, rs_high_out, rs_low_out;
   int fails = 0;
   int samples_checked = 0;
   always #10 clk_sys_in = ~clk_sys_in;
   pcrh_top #(.W(16)) dut (
      .clk_sys_in, .rstn_in, .tlg_valid_in, .rq_ident_in, .rq_index_in,
      .rq_high_in, .rq_low_in, .acyclic_in, .master_ctl_in, .change_perm_in,
      .par_req_out, .par_num_out, .par_sub_out, .par_exists_in, .par_dword_in,
      .par_field_in, .par_count_in, .par_rd_high_in, .par_rd_low_in,
      .par_desc_in, .par_ack_in, .par_wr_out, .par_save_out, .par_wr_high_out,
      .par_wr_low_out, .par_wr_status_in, .rs_ident_out, .rs_index_out,
      .rs_high_out, .rs_low_out, .busy_out
   );
   pcrh_param_model u_model (
      .clk_sys_in, .rstn_in, .req_in(par_req_out), .wr_in(par_wr_out),
      .num_in(par_num_out), .sub_in(par_sub_out), .lat_in(lat), .st_in(st),
      .ack_out(par_ack_in), .exists_out(par_exists_in),
      .dword_out(par_dword_in), .field_out(par_field_in),
      .count_out(par_count_in), .high_out(par_rd_high_in),
      .low_out(par_rd_low_in), .desc_out(par_desc_in),
      .status_out(par_wr_status_in)
   );
   function automatic logic [15:0] pk(input logic [3:0] i, logic [10:0] p);
      return {i, 1'b0, p};
   endfunction
   task automatic check(input string nm, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ====================
   // Telegram driver; words stand as a repeated request
   task automatic send(input logic [15:0] id_w, ix_w, input bit twice);
      int n;
      @(negedge clk_sys_in);
      rq_ident_in = id_w;
      rq_index_in = ix_w;
      tlg_valid_in = 1'b1;
      @(negedge clk_sys_in);
      if (twice) rq_ident_in = pk(4'h2, P5);
      if (twice) @(negedge clk_sys_in);
      tlg_valid_in = 1'b0;
      n = 0;
      while (busy_out !== 1'b0 && n < 40) begin
         @(negedge clk_sys_in);
         n++;
      end
      check("busy", {15'h0000, busy_out}, Z);
      repeat (3) @(negedge clk_sys_in);
   endtask
   task automatic run(input logic [3:0] q, input logic [10:0] p,
         input logic [15:0] ix, input logic [3:0] r,
         input logic [15:0] eh, el, input logic [1:0] m);
      send(pk(q, p), ix, 1'b0);
      check("ident", rs_ident_out, pk(r, p));
      check("index", rs_index_out, ix);
      if (m[1]) check("high", rs_high_out, eh);
      if (m[0]) check("low", rs_low_out, el);
   endtask
   always @(negedge clk_sys_in) begin
      if (par_wr_out === 1'b1) begin
         check("save", {15'h0000, par_save_out}, {15'h0000, sv_exp});
         check("wr_low", par_wr_low_out, rq_low_in);
         check("wr_high", par_wr_high_out, rq_high_in);
      end
   end
   initial begin
      repeat (4000) @(posedge clk_sys_in);
      fails++;
      print_verdict();
   end
   // ====================
   // Main sequence
   initial begin
      flt = '{16'h0001, 16'h0002, 16'h0006, 16'h000c, 16'h0011, 16'h0065,
         16'h0068, 16'h00c8, 16'h00c9, 16'h00cc, 16'h0066};
      repeat (12) @(negedge clk_sys_in);
      rstn_in = 1'b1;
      check("rst_ident", rs_ident_out, Z);
      run(4'h1, P5, Z, 4'h1, Z, 16'h5a5f, 2'h3);
      rq_high_in = 16'h00a5;
      run(4'h3, P5, 16'h0080, 4'h2, 16'h00a5, 16'h0042, 2'h3);
      rq_high_in = Z;
      run(4'h1, P5, 16'h0080, 4'h2, 16'h1234, 16'h5d8f, 2'h3);
      acyclic_in = 1'b1;
      run(4'h6, P30, 16'h0002, 4'h4, Z, 16'h5a44, 2'h3);
      run(4'h1, P5, 16'h8000, 4'h2, 16'h1234, 16'h5d8f, 2'h3);
      acyclic_in = 1'b0;
      run(4'h9, P30, Z, 4'h6, Z, 16'h0004, 2'h1);
      run(4'h4, P5, 16'h0300, 4'h3, Z, 16'h00d3, 2'h1);
      master_ctl_in = 1'b0;
      run(4'h2, P5, Z, 4'h8, Z, 16'h000b, 2'h1);
      master_ctl_in = 1'b1;
      change_perm_in = 1'b0;
      run(4'he, P5, Z, 4'h8, Z, 16'h00cc, 2'h1);
      change_perm_in = 1'b1;
      run(4'hc, P5, 16'h0100, 4'h7, Z, 16'h0004, 2'h1);
      run(4'h7, P30, 16'h0400, 4'h7, Z, 16'h0003, 2'h1);
      run(4'h2, P5, 16'h0080, 4'h7, Z, 16'h0005, 2'h1);
      for (int u = 5; u < 16; u += 5) begin
         run(u[3:0], P5, Z, 4'h7, Z, 16'h006a, 2'h1);
      end
      lat = 4'h5;
      for (int s = 1; s < 12; s++) begin
         st = s[3:0];
         sv_exp = s[0];
         run(s[0] ? 4'hd : 4'h3, P5, 16'h0080, 4'h7, Z, flt[s], 2'h1);
      end
      lat = 4'h0;
      st = 4'h0;
      sv_exp = 1'b1;
      run(4'he, P5, Z, 4'h1, Z, 16'h0042, 2'h3);
      run(4'hc, P30, 16'h0100, 4'h4, Z, 16'h0042, 2'h3);
      sv_exp = 1'b0;
      run(4'h1, 11'h000, Z, 4'h7, Z, Z, 2'h1);
      run(4'h0, P5, Z, 4'h0, Z, Z, 2'h3);
      run(4'h9, P30, Z, 4'h6, Z, 16'h0004, 2'h1);
      send(pk(4'h9, P5), Z, 1'b0);
      check("same_id", rs_ident_out, pk(4'h6, P30));
      send(pk(4'h1, P5), Z, 1'b1);
      check("busy_ign", rs_ident_out, pk(4'h1, P5));
      check("busy_low", rs_low_out, 16'h5a5f);
      rstn_in = 1'b0;
      @(negedge clk_sys_in);
      rstn_in = 1'b1;
      check("rst_low", rs_low_out, Z);
      run(4'h1, P5, Z, 4'h1, Z, 16'h5a5f, 2'h3);
      print_verdict();
   end
endmodule
